// ---- logic/ctsup_core.sv ----
/*
  Current transformer circuit supervision, evaluated once per processing
  cycle. Holds settings and read-only values behind a plain register port.
  Assumes magnitudes and angles come from pre-processing on sys_clk, valid
  at cycle_tick; the blocking and binary pick-up inputs come from pins.
*/
// The register addresses and the address-and-strobe port are this design's own decisions.
// Function
// R1: Comparators release at 97 and pick up at 103 percent of threshold.
// R2: Three phases and selected residual are compared each cycle.
// R3: Any phase above the high limit suppresses activation.
// R4: At least one phase above the low limit is required.
// R5: Minimum over maximum phase ratio must be below its setting.
// R6: Negative over positive sequence ratio must exceed its setting.
// R7: With residual selected, summed-versus-residual difference must exceed.
// R8: Alarm follows activation by a set delay in 5 ms steps.
// R9: Start is given only while blocking is inactive.
// R10: Blocking is sampled at the beginning of every processing cycle.
// R11: Blocked pick-up raises inhibited output and stops timing.
// R12: Blocking after start clears start and releases as on drop-out.
// R13: Blocking issues a display event and a stamped event with data.
// R14: Blocking source asserts at least 5 ms before the delay expires.
// R15: Only definite-time delay is supported.
// R16: Binary pick-up input activates immediately, with no comparison.
// R17: Read-only difference magnitude, 0.01 In resolution.
// R18: Read-only angle difference spanning plus and minus 360 degrees.
// R19: Read-only natural unbalance angle in 0.01 degree steps.
// R20: Timer runs only while all conditions hold together.
// R21: Residual source: 0 none, 1 first input, 2 second input.
// R22: Residual polarity: 0 adds, 1 subtracts.
// R23: Alarm and inhibited changes are stamped with 1 ms resolution.
// R24: A condition ceasing before expiry resets the timer, no alarm.
`timescale 1ns/1ns
`default_nettype none
module ctsup_core
  import ctsup_pkg::*;
#(
  parameter int MS_CYC = CTSUP_MS_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Measurements, valid at cycle_tick
  input wire logic cycle_tick,
  input wire logic [15:0] phase_a_mag,
  input wire logic [15:0] phase_b_mag,
  input wire logic [15:0] phase_c_mag,
  input wire logic [15:0] residual_input_a,
  input wire logic [15:0] residual_input_b,
  input wire logic [15:0] residual_a_ang,
  input wire logic [15:0] residual_b_ang,
  input wire logic [15:0] phase_sum_mag,
  input wire logic [15:0] phase_sum_ang,
  input wire logic [15:0] seq_pos_mag,
  input wire logic [15:0] seq_neg_mag,
  // Pins
  input wire logic block_in,
  input wire logic bin_pickup_in,
  // Outputs
  output logic start_out,
  output logic alarm_out,
  output logic inhibited_out,
  output logic alarm_evt,
  output logic inhibit_evt,
  output logic display_evt,
  output logic [31:0] evt_time,
  output logic [15:0] evt_phase_a,
  output logic [15:0] evt_phase_b,
  output logic [15:0] evt_phase_c,
  output logic [5:0] evt_fault
);
  if (MS_CYC < 2 || MS_CYC > 1000000) begin : g_ms_chk
    $error("MS_CYC out of range");
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic hyst(input logic [15:0] m,
                                input logic [15:0] t,
                                input logic prev);
    logic [23:0] a;
    logic [23:0] lo;
    logic [23:0] hi;
    a = 24'(m) * 24'(CTSUP_PCT);
    lo = 24'(t) * 24'(CTSUP_HYS_LO);
    hi = 24'(t) * 24'(CTSUP_HYS_HI);
    return prev ? (a >= lo) : (a > hi);
  endfunction

  function automatic logic [15:0] absdiff(input logic [15:0] x,
                                          input logic [15:0] y);
    return (x >= y) ? x - y : y - x;
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] blk_s_q;
  logic [2:0] bin_s_q;
  logic blk_f_q;
  logic bin_f_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      blk_s_q <= 3'h0;
      bin_s_q <= 3'h0;
      blk_f_q <= 1'b0;
      bin_f_q <= 1'b0;
    end else begin
      blk_s_q <= {blk_s_q[1:0], block_in};
      bin_s_q <= {bin_s_q[1:0], bin_pickup_in};
      if (blk_s_q[1] == blk_s_q[2])
        blk_f_q <= blk_s_q[2];
      if (bin_s_q[1] == bin_s_q[2])
        bin_f_q <= bin_s_q[2];
    end
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [1:0] sel_q;
  logic pol_q;
  logic [15:0] high_q;
  logic [15:0] low_q;
  logic [15:0] ratio_q;
  logic [15:0] seq_q;
  logic [15:0] diff_q;
  logic [18:0] dly_q;
  logic signed [18:0] nat_q;
  logic comp_req_q;
  wire wr_ctrl = reg_wr && reg_addr == CTSUP_A_CTRL;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sel_q <= CTSUP_SEL_NONE;
      pol_q <= 1'b0;
      high_q <= CTSUP_HIGH_RST;
      low_q <= CTSUP_LOW_RST;
      ratio_q <= CTSUP_RATIO_RST;
      seq_q <= CTSUP_SEQ_RST;
      diff_q <= CTSUP_DIFF_RST;
      dly_q <= CTSUP_DLY_RST;
      comp_req_q <= 1'b0;
    end else begin
      comp_req_q <= wr_ctrl && reg_wdata[CTSUP_F_COMP];
      if (wr_ctrl) begin
        sel_q <= reg_wdata[CTSUP_F_SEL +: 2]; // R21
        pol_q <= reg_wdata[CTSUP_F_POL]; // R22
      end
      if (reg_wr && reg_addr == CTSUP_A_HIGH) high_q <= reg_wdata[15:0];
      if (reg_wr && reg_addr == CTSUP_A_LOW) low_q <= reg_wdata[15:0];
      if (reg_wr && reg_addr == CTSUP_A_RATIO) ratio_q <= reg_wdata[15:0];
      if (reg_wr && reg_addr == CTSUP_A_SEQ) seq_q <= reg_wdata[15:0];
      if (reg_wr && reg_addr == CTSUP_A_DIFF) diff_q <= reg_wdata[15:0];
      if (reg_wr && reg_addr == CTSUP_A_DELAY) dly_q <= reg_wdata[18:0];
    end
  end

  // ----------------------------------------------------------------------
  // Residual path
  // ----------------------------------------------------------------------
  wire res_on = sel_q == CTSUP_SEL_A || sel_q == CTSUP_SEL_B; // R21
  wire [15:0] res_mag = (sel_q == CTSUP_SEL_B) ? residual_input_b :
                        residual_input_a;
  wire [15:0] res_ang = (sel_q == CTSUP_SEL_B) ? residual_b_ang :
                        residual_a_ang;
  wire [15:0] dmag = res_on ? absdiff(phase_sum_mag, res_mag) : 16'h0000;
  // Subtract wiring turns the residual phasor by half a turn
  wire signed [18:0] ang_raw = 19'(signed'(phase_sum_ang)) -
    19'(signed'(res_ang)) - (pol_q ? CTSUP_HALF_TURN : 19'sh0); // R22
  wire signed [18:0] ang_w = (ang_raw < -CTSUP_FULL_TURN) ?
    ang_raw + CTSUP_FULL_TURN : ang_raw; // R18
  wire signed [18:0] ang_c = ang_w - nat_q; // R19

  // ----------------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------------
  logic [2:0] hi_q;
  logic [2:0] lo_q;
  logic df_q;
  wire [2:0] hi_n;
  wire [2:0] lo_n;
  wire [15:0] ph [3];
  assign ph[0] = phase_a_mag;
  assign ph[1] = phase_b_mag;
  assign ph[2] = phase_c_mag;
  for (genvar i = 0; i < 3; i++) begin : g_cmp
    assign hi_n[i] = hyst(ph[i], high_q, hi_q[i]); // R1 R2 R3
    assign lo_n[i] = hyst(ph[i], low_q, lo_q[i]); // R1 R2 R4
  end
  wire df_n = hyst(dmag, diff_q, df_q); // R1 R2 R7
  wire [15:0] mx01 = (ph[0] > ph[1]) ? ph[0] : ph[1];
  wire [15:0] mn01 = (ph[0] > ph[1]) ? ph[1] : ph[0];
  wire [15:0] ph_max = (ph[2] > mx01) ? ph[2] : mx01;
  wire [15:0] ph_min = (ph[2] < mn01) ? ph[2] : mn01;
  wire ratio_ok = 32'(ph_min) * 32'(CTSUP_FULL) <
                  32'(ratio_q) * 32'(ph_max); // R5
  wire seq_ok = 32'(seq_neg_mag) * 32'(CTSUP_FULL) >
                32'(seq_q) * 32'(seq_pos_mag); // R6
  wire hi_any = |hi_n;
  wire lo_any = |lo_n;
  wire mag_act = !hi_any && lo_any && ratio_ok && seq_ok &&
                 (!res_on || df_n); // R3 R4 R7 R20
  wire act = mag_act || bin_f_q; // R16
  wire [5:0] fault = {bin_f_q, res_on && df_n, seq_ok, ratio_ok,
                      lo_any, hi_any};

  // ----------------------------------------------------------------------
  // Start, block and definite-time alarm
  // ----------------------------------------------------------------------
  logic start_q;
  logic alarm_q;
  logic inh_q;
  logic [18:0] tmr_q;
  // Blocking is taken from the filtered level at the tick itself
  wire blk_now = blk_f_q; // R10
  wire go = act && !blk_now; // R9
  wire due = go && tmr_q >= dly_q; // R8 R15
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hi_q <= 3'h0;
      lo_q <= 3'h0;
      df_q <= 1'b0;
      start_q <= 1'b0;
      alarm_q <= 1'b0;
      inh_q <= 1'b0;
      tmr_q <= 19'h0;
    end else if (cycle_tick) begin
      hi_q <= hi_n;
      lo_q <= lo_n;
      df_q <= df_n;
      start_q <= go; // R9 R12
      inh_q <= act && blk_now; // R11
      alarm_q <= due || (alarm_q && go); // R20 R24
      if (!go)
        tmr_q <= 19'h0; // R12 R24
      else if (!due)
        tmr_q <= tmr_q + 19'h1; // R20
    end
  end

  // ----------------------------------------------------------------------
  // Millisecond stamp, events and captured data
  // ----------------------------------------------------------------------
  logic [19:0] div_q;
  logic [31:0] ms_q;
  logic a_evt_q;
  logic i_evt_q;
  logic disp_q;
  logic [31:0] et_q;
  logic [15:0] ca_q;
  logic [15:0] cb_q;
  logic [15:0] cc_q;
  logic [5:0] cf_q;
  wire alarm_d = due || (alarm_q && go);
  wire inh_d = act && blk_now;
  wire a_chg = cycle_tick && alarm_d != alarm_q;
  wire i_chg = cycle_tick && inh_d != inh_q;
  wire cap = cycle_tick && act && !start_q && !inh_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_q <= 20'h0;
      ms_q <= 32'h0;
      a_evt_q <= 1'b0;
      i_evt_q <= 1'b0;
      disp_q <= 1'b0;
      et_q <= 32'h0;
      ca_q <= 16'h0;
      cb_q <= 16'h0;
      cc_q <= 16'h0;
      cf_q <= 6'h0;
      nat_q <= 19'sh0;
    end else begin
      if (div_q == 20'(MS_CYC - 1)) begin
        div_q <= 20'h0;
        ms_q <= ms_q + 32'h1; // R23
      end else begin
        div_q <= div_q + 20'h1;
      end
      a_evt_q <= a_chg; // R23
      i_evt_q <= i_chg; // R23
      disp_q <= i_chg && inh_d; // R13
      if (a_chg || i_chg)
        et_q <= ms_q; // R23
      // Pick-up values are frozen at activation for the blocking record
      if (cap) begin
        ca_q <= phase_a_mag; // R13
        cb_q <= phase_b_mag;
        cc_q <= phase_c_mag;
        cf_q <= fault;
      end
      if (comp_req_q)
        nat_q <= ang_w; // R19
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  always_comb begin
    case (reg_addr)
      CTSUP_A_CTRL: rd_d = {29'h0, pol_q, sel_q};
      CTSUP_A_HIGH: rd_d = {16'h0, high_q};
      CTSUP_A_LOW: rd_d = {16'h0, low_q};
      CTSUP_A_RATIO: rd_d = {16'h0, ratio_q};
      CTSUP_A_SEQ: rd_d = {16'h0, seq_q};
      CTSUP_A_DIFF: rd_d = {16'h0, diff_q};
      CTSUP_A_DELAY: rd_d = {13'h0, dly_q};
      CTSUP_A_STAT: rd_d = {20'h0, cf_q, blk_f_q, inh_q, alarm_q,
                            start_q, 2'h0};
      CTSUP_A_DMAG: rd_d = {16'h0, dmag}; // R17
      CTSUP_A_DANG: rd_d = 32'(ang_c); // R18
      CTSUP_A_NANG: rd_d = 32'(nat_q); // R19
      CTSUP_A_TIME: rd_d = ms_q;
      default: rd_d = 32'h0;
    endcase
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      rd_q <= 32'h0;
    else
      rd_q <= reg_rd ? rd_d : 32'h0;
  end

  assign reg_rdata = rd_q;
  assign start_out = start_q;
  assign alarm_out = alarm_q;
  assign inhibited_out = inh_q;
  assign alarm_evt = a_evt_q;
  assign inhibit_evt = i_evt_q;
  assign display_evt = disp_q;
  assign evt_time = et_q;
  assign evt_phase_a = ca_q;
  assign evt_phase_b = cb_q;
  assign evt_phase_c = cc_q;
  assign evt_fault = cf_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_hyst;
    cycle_tick && hi_q[0] &&
      24'(phase_a_mag) * 24'(CTSUP_PCT) >= 24'(high_q) * 24'(CTSUP_HYS_LO)
      |=> hi_q[0];
  endproperty
  a_hyst: assert property (p_hyst) else $error("release too early"); // R1
  property p_high;
    cycle_tick && hi_any && !bin_f_q |=> !start_q && !inh_q;
  endproperty
  a_high: assert property (p_high) else $error("start above high"); // R3
  property p_low;
    cycle_tick && !lo_any && !bin_f_q |=> !start_q && !alarm_q;
  endproperty
  a_low: assert property (p_low) else $error("start below low"); // R4
  property p_start;
    cycle_tick && act && !blk_f_q |=> start_q && !inh_q;
  endproperty
  a_start: assert property (p_start) else $error("no start"); // R9
  property p_block;
    cycle_tick && act && blk_f_q |=> inh_q && !start_q && !alarm_q;
  endproperty
  a_block: assert property (p_block) else $error("block ignored"); // R11
  property p_drop;
    cycle_tick && !act |=> !alarm_q && tmr_q == 19'h0;
  endproperty
  a_drop: assert property (p_drop) else $error("timer kept"); // R24
  property p_delay;
    $rose(alarm_q) |-> start_q && $past(tmr_q) == dly_q;
  endproperty
  a_delay: assert property (p_delay) else $error("bad delay"); // R8
  property p_stamp;
    $changed(alarm_q) |-> alarm_evt && evt_time == $past(ms_q);
  endproperty
  a_stamp: assert property (p_stamp) else $error("no stamp"); // R23
  property p_disp;
    $rose(inh_q) |-> display_evt ##1 !display_evt;
  endproperty
  a_disp: assert property (p_disp) else $error("no display"); // R13
  c_alarm: cover property ($rose(alarm_q));
  c_block: cover property ($fell(start_q) && inh_q);
  c_abort: cover property (start_q ##1 !start_q && !alarm_q);
endmodule
`default_nettype wire

// ---- inc/ctsup_pkg.sv ----
/*
  Shared constants for the current transformer circuit supervision block:
  register offsets, reset values of the settings, hysteresis points, cycle
  counts. Assumes a 100 MHz system clock and magnitudes in 0.01 x In.
*/
package ctsup_pkg;
  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTSUP_A_CTRL = 8'h00;
  localparam logic [7:0] CTSUP_A_HIGH = 8'h04;
  localparam logic [7:0] CTSUP_A_LOW = 8'h08;
  localparam logic [7:0] CTSUP_A_RATIO = 8'h0C;
  localparam logic [7:0] CTSUP_A_SEQ = 8'h10;
  localparam logic [7:0] CTSUP_A_DIFF = 8'h14;
  localparam logic [7:0] CTSUP_A_DELAY = 8'h18;
  localparam logic [7:0] CTSUP_A_STAT = 8'h1C;
  localparam logic [7:0] CTSUP_A_DMAG = 8'h20;
  localparam logic [7:0] CTSUP_A_DANG = 8'h24;
  localparam logic [7:0] CTSUP_A_NANG = 8'h28;
  localparam logic [7:0] CTSUP_A_TIME = 8'h2C;
  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int CTSUP_F_SEL = 0;
  localparam int CTSUP_F_POL = 2;
  localparam int CTSUP_F_COMP = 3;
  localparam logic [1:0] CTSUP_SEL_NONE = 2'h0;
  localparam logic [1:0] CTSUP_SEL_A = 2'h1;
  localparam logic [1:0] CTSUP_SEL_B = 2'h2;
  // ----------------------------------------------------------------------
  // Reset values of the settings
  // ----------------------------------------------------------------------
  localparam logic [15:0] CTSUP_HIGH_RST = 16'h0078;
  localparam logic [15:0] CTSUP_LOW_RST = 16'h000A;
  localparam logic [15:0] CTSUP_RATIO_RST = 16'h03E8;
  localparam logic [15:0] CTSUP_SEQ_RST = 16'h1324;
  localparam logic [15:0] CTSUP_DIFF_RST = 16'h000A;
  localparam int CTSUP_DLY_STEP_MS = 5;
  localparam int CTSUP_DLY_DEF_MS = 500;
  localparam logic [18:0] CTSUP_DLY_RST =
    19'(CTSUP_DLY_DEF_MS / CTSUP_DLY_STEP_MS);
  // ----------------------------------------------------------------------
  // Hysteresis points in percent of the threshold
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTSUP_HYS_LO = 8'h61;
  localparam logic [7:0] CTSUP_HYS_HI = 8'h67;
  localparam logic [7:0] CTSUP_PCT = 8'h64;
  localparam logic [15:0] CTSUP_FULL = 16'h2710;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CTSUP_CLK_NS = 10;
  localparam int CTSUP_STAMP_NS = 1000000;
  localparam int CTSUP_MS_CYC = CTSUP_STAMP_NS / CTSUP_CLK_NS;
  localparam logic signed [18:0] CTSUP_HALF_TURN = 19'sh0_4650;
  localparam logic signed [18:0] CTSUP_FULL_TURN = 19'sh0_8CA0;
endpackage

// ---- tb/ctsup_meas_model.sv ----
/* Stand-in for measurement pre-processing and the blocking matrix.
   Assumes the bench holds the magnitudes and asks for each tick. */
`timescale 1ns/1ns
`default_nettype none
module ctsup_meas_model
  import ctsup_pkg::*;
#(
  parameter int LEAD = 6
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Requests from the bench
  input wire logic tick_req,
  input wire logic slow,
  input wire logic blk_req,
  input wire logic bin_req,
  // Towards the block
  output logic cycle_tick,
  output logic block_in,
  output logic bin_pickup_in
);
  int cnt;
  // ------------------------------------------------------------------
  // Pins move first; the tick waits until the pin filters settled
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      cycle_tick <= 1'b0;
      block_in <= 1'b0;
      bin_pickup_in <= 1'b0;
    end else begin
      cycle_tick <= 1'b0;
      if (tick_req) begin
        block_in <= blk_req;
        bin_pickup_in <= bin_req;
        cnt <= slow ? 3 * LEAD : LEAD;
      end else if (cnt == 1) begin
        cycle_tick <= 1'b1;
        cnt <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
/* Self-checking bench for the supervision core, compared at every tick
   with an integer model. Assumes the measurement model is compiled. */
`timescale 1ns/1ns
`default_nettype none
module testbench
  import ctsup_pkg::*;
;
  localparam int MS = 10;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tick_req = 1'b0;
  logic slow = 1'b0;
  logic blk = 1'b0;
  logic bin = 1'b0;
  logic [15:0] ph[3] = '{16'h0, 16'h0, 16'h0};
  logic [15:0] ra = 16'h0;
  logic [15:0] rb = 16'h0;
  logic [15:0] sm = 16'h0;
  logic [15:0] pos = 16'h0;
  logic [15:0] neg = 16'h0;
  logic [15:0] ang_a = 16'h0;
  logic [15:0] ang_s = 16'h0;
  logic [31:0] reg_rdata, evt_time;
  logic cycle_tick, block_in, bin_pickup_in;
  logic start_out, alarm_out, inhibited_out;
  logic alarm_evt, inhibit_evt, display_evt;
  logic [15:0] evt_phase_a, evt_phase_b, evt_phase_c;
  logic [5:0] evt_fault;
  logic [31:0] m_ab = '0;
  logic [31:0] m_cf = '0;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 8548;
  int s_hi = 120, s_lo = 10, s_rat = 1000, s_seq = 4900, s_dif = 10;
  int s_dly = 100, s_sel = 0, m_n = 0;
  bit m_st, m_al, m_in, hd;
  bit hh[3], hl[3];

  ctsup_meas_model src (
    .sys_clk(sys_clk), .rst(rst), .tick_req(tick_req), .slow(slow),
    .blk_req(blk), .bin_req(bin), .cycle_tick(cycle_tick),
    .block_in(block_in), .bin_pickup_in(bin_pickup_in)
  );
  ctsup_core #(.MS_CYC(MS)) dut (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cycle_tick(cycle_tick),
    .phase_a_mag(ph[0]), .phase_b_mag(ph[1]), .phase_c_mag(ph[2]),
    .residual_input_a(ra), .residual_input_b(rb),
    .residual_a_ang(ang_a), .residual_b_ang(ang_a),
    .phase_sum_mag(sm), .phase_sum_ang(ang_s),
    .seq_pos_mag(pos), .seq_neg_mag(neg),
    .block_in(block_in), .bin_pickup_in(bin_pickup_in),
    .start_out(start_out), .alarm_out(alarm_out),
    .inhibited_out(inhibited_out), .alarm_evt(alarm_evt),
    .inhibit_evt(inhibit_evt), .display_evt(display_evt),
    .evt_time(evt_time), .evt_phase_a(evt_phase_a),
    .evt_phase_b(evt_phase_b), .evt_phase_c(evt_phase_c),
    .evt_fault(evt_fault)
  );

  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (!rst) cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cmp_reg(logic [31:0] got, logic [31:0] exp, string w);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask

  task automatic cmp_out(logic [2:0] got, logic [2:0] exp, string w);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %b exp %b", $time, w, got, exp);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    case (a)
      CTSUP_A_CTRL: s_sel = int'(d[1:0]);
      CTSUP_A_LOW: s_lo = d;
      CTSUP_A_DELAY: s_dly = d;
      default: ;
    endcase
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] q);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask

  task automatic meas(int a, int b, int c, int p, int n);
    @(posedge sys_clk);
    ph[0] <= 16'(a);
    ph[1] <= 16'(b);
    ph[2] <= 16'(c);
    pos <= 16'(p);
    neg <= 16'(n);
  endtask

  // Comparator with release at 97 and pick-up above 103 percent
  function automatic bit hy(int m, int t, bit p);
    return p ? (m * 100 >= t * 97) : (m * 100 > t * 103);
  endfunction

  task automatic tick(bit b, bit pk);
    int m[3];
    int mx, mn, r;
    bit hi, lo, act, pa, pi, ren, rk, sk;
    @(posedge sys_clk);
    tick_req <= 1'b1;
    blk <= b;
    bin <= pk;
    m = '{int'(ph[0]), int'(ph[1]), int'(ph[2])};
    mx = 0;
    mn = 65535;
    hi = 0;
    lo = 0;
    for (int i = 0; i < 3; i++) begin
      hh[i] = hy(m[i], s_hi, hh[i]);
      hl[i] = hy(m[i], s_lo, hl[i]);
      hi |= hh[i];
      lo |= hl[i];
      mx = m[i] > mx ? m[i] : mx;
      mn = m[i] < mn ? m[i] : mn;
    end
    r = s_sel == 1 ? int'(ra) : int'(rb);
    ren = s_sel == 1 || s_sel == 2;
    // An unselected residual feeds zero, so its comparator releases
    hd = hy(ren ? (r > sm ? r - sm : sm - r) : 0, s_dif, hd);
    rk = mn * 10000 < s_rat * mx;
    sk = neg * 10000 > s_seq * pos;
    act = pk || (!hi && lo && rk && sk && (hd || !ren));
    // Record is frozen at the first tick of an activation
    if (act && !m_st && !m_in) begin
      m_ab = {ph[0], ph[1]};
      m_cf = {10'h0, pk, ren && hd, sk, rk, lo, hi, ph[2]};
    end
    pa = m_al;
    pi = m_in;
    m_in = act && b;
    m_st = act && !b;
    m_n = m_st ? m_n + 1 : 0;
    m_al = m_st && m_n > s_dly;
    @(posedge sys_clk);
    tick_req <= 1'b0;
    for (int i = 0; i < 60 && cycle_tick !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    // Levels and event pulses are launched by the same tick edge
    @(posedge sys_clk);
    #1 cmp_out({start_out, alarm_out, inhibited_out},
               {m_st, m_al, m_in}, "lvl");
    cmp_out({alarm_evt, inhibit_evt, display_evt},
            {pa != m_al, pi != m_in, !pi && m_in}, "evt");
    cmp_reg({evt_phase_a, evt_phase_b}, m_ab, "cap");
    cmp_reg({10'h0, evt_fault, evt_phase_c}, m_cf, "cap");
    if (pa != m_al)
      cmp_reg(evt_time, 32'((cyc - 1) / MS), "t");
  endtask

  initial begin
    logic [31:0] q, a0;
    logic [7:0] adr[6] = '{CTSUP_A_HIGH, CTSUP_A_LOW, CTSUP_A_RATIO,
                           CTSUP_A_SEQ, CTSUP_A_DIFF, CTSUP_A_DELAY};
    int dflt[6] = '{120, 10, 1000, 4900, 10, 100};
    int lv[5] = '{50, 103, 104, 97, 96};
    int r;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rd(CTSUP_A_CTRL, q);
    cmp_reg(q, 0, "ctrl");
    for (int i = 0; i < 6; i++) begin
      rd(adr[i], q);
      cmp_reg(q, dflt[i], "default");
    end
    rd(8'h30, q);
    cmp_reg(q, 0, "unmapped");
    wr(CTSUP_A_DMAG, 32'hFFFF);
    rd(CTSUP_A_DMAG, q);
    cmp_reg(q, 0, "read-only");
    wr(CTSUP_A_DELAY, 2);
    meas(100, 100, 0, 67, 33);
    repeat (4) tick(0, 0);
    meas(100, 100, 100, 100, 0);
    tick(0, 0);
    meas(100, 100, 0, 67, 33);
    repeat (2) tick(0, 0);
    meas(100, 100, 0, 100, 20);
    tick(0, 0);
    meas(130, 130, 0, 67, 33);
    tick(0, 0);
    wr(CTSUP_A_LOW, 100);
    foreach (lv[i]) begin
      meas(lv[i], lv[i], 0, 67, 33);
      tick(0, 0);
    end
    wr(CTSUP_A_LOW, 10);
    meas(100, 100, 0, 67, 33);
    tick(1, 0);
    repeat (3) tick(0, 0);
    tick(1, 0);
    meas(100, 100, 100, 100, 0);
    tick(0, 1);
    tick(1, 1);
    tick(0, 0);
    @(posedge sys_clk);
    ra <= 16'h32;
    rb <= 16'h14;
    meas(100, 100, 0, 67, 33);
    for (int s = 0; s < 4; s++) begin
      wr(CTSUP_A_CTRL, s);
      for (int k = 50; k < 100; k += 30) begin
        @(posedge sys_clk);
        sm <= 16'(k);
        tick(0, 0);
        rd(CTSUP_A_DMAG, q);
        cmp_reg(q, s == 1 ? k - 50 : s == 2 ? k - 20 : 0, "dmag");
      end
    end
    wr(CTSUP_A_CTRL, 1);
    @(posedge sys_clk);
    ang_s <= 16'h0BB8;
    ang_a <= 16'h03E8;
    tick(0, 0);
    rd(CTSUP_A_DANG, a0);
    wr(CTSUP_A_CTRL, 5);
    tick(0, 0);
    rd(CTSUP_A_DANG, q);
    q = q - a0;
    cmp_reg({31'h0, q === 32'h4650 || q === 32'hFFFFB9B0}, 1, "pol");
    wr(CTSUP_A_CTRL, 32'h9);
    rd(CTSUP_A_NANG, q);
    cmp_reg(q, 32'h7D0, "nat");
    rd(CTSUP_A_DANG, q);
    cmp_reg(q, 0, "comp");
    for (int i = 0; i < 40; i++) begin
      wr(CTSUP_A_CTRL, 32'({$random(seed)} % 4));
      r = {$random(seed)} % 200;
      @(posedge sys_clk);
      slow <= 1'($random(seed));
      ph[0] <= 16'(20 + {$random(seed)} % 90);
      ph[1] <= 16'(20 + {$random(seed)} % 90);
      ph[2] <= $random(seed) & 1 ? 16'h0 : 16'h3C;
      neg <= $random(seed) & 1 ? 16'h14 : 16'h3C;
      ra <= 16'(r);
      sm <= 16'(r + ($random(seed) & 1) * 50);
      tick({$random(seed)} % 4 == 0, {$random(seed)} % 8 == 0);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
